//--- logic/srctl_top.v
// system reset controller: gathers reset sources and forces the chip state
`timescale 1ns/1ps
`default_nettype none
`include "srctl_regs.vh"
module srctl_top (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // reset sources
  input wire ext_reset_pin_n_i,
  input wire supply_voltage_monitor_low,
  input wire power_on_detect,
  input wire other_reset_req,
  input wire shutdown_mode,
  // chip control
  output reg sys_reset_q,
  output reg core_halt_q,
  output reg por_reset_q,
  output reg irq_timer_disable_q,
  output reg ram_clear_q,
  output reg [`SRCTL_PC_W-1:0] pc_load_q,
  output reg [`SRCTL_CLKSEL_W-1:0] sysclk_sel_q,
  output reg wdt_enable_q,
  output reg wdt_src_lfo_q,
  // port pins
  output reg [`SRCTL_NPORT-1:0] port_latch_q,
  output reg [`SRCTL_NPORT-1:0] port_open_drain_q,
  output reg pullup_enable_q,
  output reg port_force_q,
  // reset pin drive
  output reg ext_reset_pin_o_q,
  output reg ext_reset_pin_oe_n_q
);
  ////////////////////////////////////////////////////////////////
  // synchronisers for pin-side sources
  reg [1:0] pin_s_q;
  reg [1:0] mon_s_q;
  reg [1:0] por_s_q;
  reg [1:0] oth_s_q;
  reg [1:0] shd_s_q;
  always @(posedge clk) begin
    pin_s_q <= {pin_s_q[0], ~ext_reset_pin_n_i};
    mon_s_q <= {mon_s_q[0], supply_voltage_monitor_low};
    por_s_q <= {por_s_q[0], power_on_detect};
    oth_s_q <= {oth_s_q[0], other_reset_req};
    shd_s_q <= {shd_s_q[0], shutdown_mode};
  end
  ////////////////////////////////////////////////////////////////
  // source merge
  // own low drive of the reset pin must not read back as a request,
  // including the two cycles the synchroniser still shows it
  reg [1:0] drv_s_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      drv_s_q <= 2'h3;
    end else begin
      drv_s_q <= {drv_s_q[0], ~ext_reset_pin_oe_n_q};
    end
  end
  wire pin_req = pin_s_q[1] & ext_reset_pin_oe_n_q & ~(|drv_s_q);
  wire pwr_req = mon_s_q[1] | por_s_q[1];
  // in shutdown only pin and power-on count
  wire any_req = shd_s_q[1] ? (pin_req | por_s_q[1]) : (pin_req | pwr_req | oth_s_q[1]);
  wire pwr_cause = shd_s_q[1] ? por_s_q[1] : pwr_req;
  ////////////////////////////////////////////////////////////////
  // sequencer
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`SRCTL_CNT_W-1:0] cnt_q;
  reg [`SRCTL_CNT_W-1:0] cnt_d;
  reg pwr_cause_q;
  reg pwr_cause_d;
  localparam [`SRCTL_CNT_W-1:0] REL_CYC = `SRCTL_RELEASE_CYC;
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    pwr_cause_d = pwr_cause_q;
    case (state_q)
      `SRCTL_ST_RESET: begin
        cnt_d = {`SRCTL_CNT_W{1'b0}};
        state_d = `SRCTL_ST_HOLD;
      end
      `SRCTL_ST_HOLD: begin
        if (any_req) begin
          cnt_d = {`SRCTL_CNT_W{1'b0}};
          pwr_cause_d = pwr_cause_q | pwr_cause;
        end else if (cnt_q == REL_CYC - 8'h01) begin
          state_d = `SRCTL_ST_RUN;
          pwr_cause_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      `SRCTL_ST_RUN: begin
        if (any_req) begin
          state_d = `SRCTL_ST_HOLD;
          cnt_d = {`SRCTL_CNT_W{1'b0}};
          pwr_cause_d = pwr_cause;
        end
      end
      default: state_d = `SRCTL_ST_RESET;
    endcase
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q <= `SRCTL_ST_RESET;
      cnt_q <= {`SRCTL_CNT_W{1'b0}};
      pwr_cause_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pwr_cause_q <= pwr_cause_d;
    end
  end
  ////////////////////////////////////////////////////////////////
  // chip-state outputs, all registered
  wire in_rst_d = (state_d != `SRCTL_ST_RUN);
  always @(posedge clk) begin
    if (!rst_n) begin
      sys_reset_q <= 1'b1;
      core_halt_q <= 1'b1;
      por_reset_q <= 1'b1;
      irq_timer_disable_q <= 1'b1;
      ram_clear_q <= 1'b0;
      pc_load_q <= `SRCTL_PC_RESET;
      sysclk_sel_q <= `SRCTL_CLKSEL_LPOSC;
      wdt_enable_q <= 1'b1;
      wdt_src_lfo_q <= `SRCTL_WDT_SRC_LFO;
      port_latch_q <= {`SRCTL_NPORT{1'b1}};
      port_open_drain_q <= {`SRCTL_NPORT{1'b1}};
      pullup_enable_q <= 1'b1;
      port_force_q <= 1'b1;
      ext_reset_pin_o_q <= 1'b0;
      ext_reset_pin_oe_n_q <= 1'b0;
    end else begin
      sys_reset_q <= in_rst_d;
      core_halt_q <= in_rst_d;
      por_reset_q <= in_rst_d & por_s_q[1];
      irq_timer_disable_q <= in_rst_d;
      ram_clear_q <= 1'b0;
      port_force_q <= in_rst_d;
      pullup_enable_q <= 1'b1;
      ext_reset_pin_o_q <= 1'b0;
      ext_reset_pin_oe_n_q <= ~(in_rst_d & (pwr_cause_d | pwr_cause));
      if (in_rst_d) begin
        pc_load_q <= `SRCTL_PC_RESET;
        sysclk_sel_q <= `SRCTL_CLKSEL_LPOSC;
        wdt_enable_q <= 1'b1;
        wdt_src_lfo_q <= `SRCTL_WDT_SRC_LFO;
        port_latch_q <= {`SRCTL_NPORT{1'b1}};
        port_open_drain_q <= {`SRCTL_NPORT{1'b1}};
      end
    end
  end
endmodule // srctl_top
`default_nettype wire

//--- logic/srctl_regs.vh
// constants for the system reset controller
`ifndef SRCTL_REGS_VH
`define SRCTL_REGS_VH
`define SRCTL_NPORT 8
`define SRCTL_PC_W 16
`define SRCTL_PC_RESET 16'h0000
`define SRCTL_CLKSEL_W 2
`define SRCTL_CLKSEL_LPOSC 2'h0
`define SRCTL_WDT_SRC_LFO 1'h1
`define SRCTL_RELEASE_NS 80
`define SRCTL_CLK_MHZ 100
// quiet time before release: 80 ns at 100 MHz, sized to the counter width
`define SRCTL_RELEASE_CYC 8'h08
`define SRCTL_CNT_W 8
`define SRCTL_ST_RESET 2'h0
`define SRCTL_ST_HOLD 2'h1
`define SRCTL_ST_RUN 2'h2
`endif

//--- tb/srctl_properties.sv
// reset controller assertions
`timescale 1ns/1ps
`default_nettype none
module srctl_properties (
  // watched ports
  input wire clk, rst_n, ext_reset_pin_n_i, supply_voltage_monitor_low, power_on_detect,
  input wire shutdown_mode, sys_reset_q, core_halt_q, irq_timer_disable_q, ext_reset_pin_oe_n_q,
  input wire [15:0] pc_load_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req; (!ext_reset_pin_n_i && ext_reset_pin_oe_n_q) [*4]; endsequence
  property p_halt; core_halt_q == sys_reset_q; endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_irq; irq_timer_disable_q == sys_reset_q; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_pin; !ext_reset_pin_oe_n_q |-> sys_reset_q; endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_req; s_req |-> ##2 sys_reset_q; endproperty
  a_req: assert property (p_req) else $error("req");
  property p_mon; (supply_voltage_monitor_low && !shutdown_mode) [*4] |-> ##2 !ext_reset_pin_oe_n_q; endproperty
  a_mon: assert property (p_mon) else $error("mon");
  property p_exit; $fell(sys_reset_q) |-> !pc_load_q; endproperty
  a_exit: assert property (p_exit) else $error("exit");
  property p_shut; (shutdown_mode && ext_reset_pin_n_i && !power_on_detect) [*6] |-> !$rose(sys_reset_q); endproperty
  a_shut: assert property (p_shut) else $error("shut");
  property p_rel; $fell(sys_reset_q) |-> !$past(power_on_detect, 5); endproperty
  a_rel: assert property (p_rel) else $error("rel");
endmodule // srctl_properties
bind srctl_top srctl_properties chk (.*);
`default_nettype wire

//--- tb/srctl_far.sv
// far-side reset pin driver on a pulled-up wire
`timescale 1ns/1ps
`default_nettype none
module srctl_far (
  // pin side
  input wire push_n, oe_n, po,
  output wire pin
);
  assign pin = push_n & (oe_n | po);
endmodule // srctl_far
`default_nettype wire

//--- tb/tb_top.sv
// reset controller bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, push_n = 1, mon = 0, por = 1, oth = 0, sd = 0;
  wire pin, sr, oe_n, po, pu;
  wire [15:0] pc;
  integer seed = 32'hb35b, bad_count = 0, comparisons = 0, i, k;
  initial forever #5 clk = ~clk;
  srctl_far far (.push_n, .oe_n, .po, .pin);
  srctl_top dut (.clk, .rst_n, .ext_reset_pin_n_i(pin), .supply_voltage_monitor_low(mon), .power_on_detect(por),
    .other_reset_req(oth), .shutdown_mode(sd), .sys_reset_q(sr), .core_halt_q(), .por_reset_q(),
    .irq_timer_disable_q(), .ram_clear_q(), .pc_load_q(pc), .sysclk_sel_q(), .wdt_enable_q(), .wdt_src_lfo_q(),
    .port_latch_q(), .port_open_drain_q(), .pullup_enable_q(pu), .port_force_q(), .ext_reset_pin_o_q(po),
    .ext_reset_pin_oe_n_q(oe_n));
  task cmp(string n, logic [16:0] x, g);
    comparisons++;
    if (g !== x) $display("unexpected %s exp %h got %h", n, x, g);
    bad_count += g !== x;
  endtask
  task report_and_stop;
    $display("%0d checks %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // pin and power-on always count, others not in shutdown
  function logic hit(integer kd, logic s);
    return kd % 3 == 0 || !s;
  endfunction
  // hold one source, check, release, wait for exit
  task go(integer kd, logic s, integer n);
    {push_n, mon, oth, por, sd} = {kd != 0, kd == 1, kd == 2, kd == 3, s};
    repeat (n) @(posedge clk);
    #1 cmp("reset", hit(kd, s), sr);
    cmp("pin", !(hit(kd, s) && kd % 2), oe_n);
    {push_n, mon, oth, por, sd} = 5'h10;
    for (k = 0; k < 40 && sr !== 0; k++) @(posedge clk);
    #1 cmp("exit", 17'h1, {pc, pu});
    cmp("run", 17'h0, sr);
    $display("test kind %0d done", kd);
  endtask
  initial begin
    #50000 bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    por = 0;
    for (k = 0; k < 60 && sr !== 0; k++) @(posedge clk);
    #1 cmp("boot", 17'h0, sr);
    for (i = 0; i < 40; i++)
      go(i % 4, i < 8 ? i / 4 : $random(seed), 7 + (i < 8 ? 0 : {$random(seed)} % 5));
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
